// [sci_dev.sv]
// Operation
// - Activate on command falling edge with card present
// - Card reset follows host reset level
// - Host supply lockout disables all card pins
// - Interrupt is active low, idles high
// - Interrupt while a card is present
// - Interrupt on card supply overload
// - Serial data relays low either way
// - First auxiliary line relays to C4
// - Second auxiliary line relays to C8
// - Debounce card insertion about 8 ms
// - Card clock divided by select inputs
// - Voltage select high picks higher supply
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sci_dev
  import sci_pkg::*;
#(
  parameter int unsigned DEBOUNCE = DEBOUNCE_CYC
) (
  input  wire logic              clock_i,
  input  wire logic              resetn_i,
  input  wire logic              ce_i,
  sci_if.dev                     hif,
  input  wire logic              host_supply_low_i,
  input  wire logic              supply_overload_i,
  input  wire logic              card_presence_in_n_i,
  input  wire logic              card_presence_in_i,
  input  wire logic [NLINES-1:0] card_line_i,
  output logic                   card_supply_out_o,
  output logic                   card_supply_high_o,
  output logic                   card_reset_out_o,
  output logic                   card_clock_out_o,
  output logic      [NLINES-1:0] card_line_o,
  output logic      [NLINES-1:0] card_line_oe,
  output logic                   card_active_o
);
  localparam int unsigned CW = $clog2(DEBOUNCE + 1);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] s1_r;
  logic [SYNC_W-1:0] s2_r;
  logic              cmd_n_s;
  logic              host_rst_s;
  logic              ext_clk_s;
  logic [1:0]        div_sel_s;
  logic              vsel_s;
  logic [NLINES-1:0] host_s;
  logic              low_s;
  logic              ovl_s;
  logic              pres_n_s;
  logic              pres_s;
  logic [NLINES-1:0] card_s;
  assign raw = {hif.activation_command_n, hif.host_reset_in, hif.ext_clock_in,
                hif.divider_select_hi, hif.divider_select_lo, hif.card_voltage_select,
                hif.host_line, host_supply_low_i, supply_overload_i,
                card_presence_in_n_i, card_presence_in_i, card_line_i};
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
    end else if (ce_i) begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end
  assign {cmd_n_s, host_rst_s, ext_clk_s, div_sel_s, vsel_s, host_s,
          low_s, ovl_s, pres_n_s, pres_s, card_s} = s2_r;

  // ---------------------------------------------------------------
  // Card presence debounce
  // ---------------------------------------------------------------
  logic          present_raw;
  logic [CW-1:0] deb_cnt_r;
  logic          present_r;
  // Either presence input may be wired, so either polarity counts
  assign present_raw = ~pres_n_s | pres_s;
  // Removal is taken at once; only insertion waits out contact bounce
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      deb_cnt_r <= '0;
      present_r <= 1'b0;
    end else if (ce_i) begin
      if (!present_raw) begin
        deb_cnt_r <= '0;
        present_r <= 1'b0;
      end else if (!present_r) begin
        if (deb_cnt_r == CW'(DEBOUNCE - 1)) begin
          present_r <= 1'b1;
        end else begin
          deb_cnt_r <= deb_cnt_r + CW'(1);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Activation control
  // ---------------------------------------------------------------
  sci_state_e state_r;
  logic       cmd_prev_r;
  logic       cmd_fall;
  logic       pins_en;
  logic [2:0] deact_cnt_r;
  assign cmd_fall = cmd_prev_r & ~cmd_n_s;
  assign pins_en  = (state_r == SCI_ACTIVE) & ~low_s;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_prev_r <= 1'b1;
    end else if (ce_i) begin
      cmd_prev_r <= cmd_n_s;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r     <= SCI_IDLE;
      deact_cnt_r <= '0;
    end else if (ce_i) begin
      case (state_r)
        SCI_IDLE: begin
          // A held-low command does not restart; only a new edge does
          if (cmd_fall && present_r && !low_s && !ovl_s) begin
            state_r <= SCI_ACTIVE;
          end
        end
        SCI_ACTIVE: begin
          if (cmd_n_s || !present_r || ovl_s || low_s) begin
            state_r     <= SCI_DEACT;
            deact_cnt_r <= 3'(DEACT_CYC - 1);
          end
        end
        SCI_DEACT: begin
          if (deact_cnt_r == 3'h0) begin
            state_r <= SCI_IDLE;
          end else begin
            deact_cnt_r <= deact_cnt_r - 3'h1;
          end
        end
        default: begin
          state_r <= SCI_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Interrupt
  // ---------------------------------------------------------------
  logic ovl_flag_r;
  logic irq_r;
  // Overload is sticky until the host lets the command go high;
  // a new overload in that very cycle still wins
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovl_flag_r <= 1'b0;
    end else if (ce_i) begin
      if (ovl_s) begin
        ovl_flag_r <= 1'b1;
      end else if (cmd_n_s) begin
        ovl_flag_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_r <= 1'b0;
    end else if (ce_i) begin
      irq_r <= present_r | ovl_flag_r;
    end
  end

  // Open drain: only ever pulls low, pull-up gives the idle high
  assign hif.irq_n_o  = 1'b0;
  assign hif.irq_n_oe = irq_r;

  // ---------------------------------------------------------------
  // Card supply, reset and clock
  // ---------------------------------------------------------------
  logic       ext_prev_r;
  logic [2:0] div_cnt_r;
  logic       clk_pick;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_prev_r <= 1'b0;
      div_cnt_r  <= '0;
    end else if (ce_i) begin
      ext_prev_r <= ext_clk_s;
      if (ext_clk_s && !ext_prev_r) begin
        div_cnt_r <= div_cnt_r + 3'h1;
      end
    end
  end

  always_comb begin
    case (div_sel_s)
      2'h0:    clk_pick = ext_clk_s;
      2'h1:    clk_pick = div_cnt_r[0];
      2'h2:    clk_pick = div_cnt_r[1];
      default: clk_pick = div_cnt_r[2];
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      card_supply_out_o  <= 1'b0;
      card_supply_high_o <= 1'b0;
      card_reset_out_o   <= 1'b0;
      card_clock_out_o   <= 1'b0;
    end else if (ce_i) begin
      card_supply_out_o  <= pins_en;
      card_supply_high_o <= pins_en & vsel_s;
      card_reset_out_o   <= pins_en & host_rst_s;
      card_clock_out_o   <= pins_en & clk_pick;
    end
  end

  assign card_active_o = (state_r == SCI_ACTIVE);

  // ---------------------------------------------------------------
  // Open-drain relays: serial data, C4, C8
  // ---------------------------------------------------------------
  // Whichever side pulls low first owns the line until it lets go;
  // the guard hides our own release still echoing through the sync.
  logic [NLINES-1:0] drv_card_r;
  logic [NLINES-1:0] drv_host_r;
  genvar gi;
  generate
    for (gi = 0; gi < NLINES; gi++) begin : g_relay
      logic [2:0] guard_r;
      always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          drv_card_r[gi] <= 1'b0;
          drv_host_r[gi] <= 1'b0;
          guard_r        <= '0;
        end else if (ce_i) begin
          if (!pins_en) begin
            drv_card_r[gi] <= 1'b0;
            drv_host_r[gi] <= 1'b0;
            guard_r        <= '0;
          end else if (drv_card_r[gi]) begin
            if (host_s[gi]) begin
              drv_card_r[gi] <= 1'b0;
              guard_r        <= 3'(GUARD_CYC);
            end
          end else if (drv_host_r[gi]) begin
            if (card_s[gi]) begin
              drv_host_r[gi] <= 1'b0;
              guard_r        <= 3'(GUARD_CYC);
            end
          end else if (guard_r != 3'h0) begin
            guard_r <= guard_r - 3'h1;
          end else if (!host_s[gi]) begin
            drv_card_r[gi] <= 1'b1;
          end else if (!card_s[gi]) begin
            drv_host_r[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate
  assign card_line_o     = '0;
  assign card_line_oe    = drv_card_r;
  assign hif.dev_line_o  = '0;
  assign hif.dev_line_oe = drv_host_r;
endmodule
`default_nettype wire

// [sci_pkg.sv]
`default_nettype none
package sci_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned DEBOUNCE_MS  = 8;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned DEACT_CYC    = 4;
  // Must outlast the two-flop input delay plus the line's own rise
  localparam int unsigned GUARD_CYC    = 4;

  // ---------------------------------------------------------------
  // Line indices and reset values
  // ---------------------------------------------------------------
  localparam int unsigned NLINES   = 3;
  localparam int unsigned LINE_IO  = 0;
  localparam int unsigned LINE_C4  = 1;
  localparam int unsigned LINE_C8  = 2;
  localparam int unsigned SYNC_W   = 16;
  localparam logic [15:0] SYNC_RST = 16'h8397;

  // ---------------------------------------------------------------
  // Controller registers, APB
  // ---------------------------------------------------------------
  localparam logic [11:0] CTRL_OFF    = 12'h000;
  localparam logic [11:0] STAT_OFF    = 12'h004;
  localparam logic [11:0] XDIV_OFF    = 12'h008;
  localparam int unsigned CTRL_W      = 11;
  localparam logic [10:0] CTRL_RST    = 11'h000;
  localparam int unsigned CTRL_ACT    = 0;
  localparam int unsigned CTRL_RESET  = 1;
  localparam int unsigned CTRL_VSEL   = 2;
  localparam int unsigned CTRL_DIV_LO = 3;
  localparam int unsigned CTRL_DIV_HI = 4;
  localparam int unsigned CTRL_PULL   = 8;
  localparam logic [7:0]  XDIV_RST    = 8'h01;
  localparam int unsigned STAT_IRQ    = 0;
  localparam int unsigned STAT_LINE   = 1;

  // ---------------------------------------------------------------
  // Device states, Gray along idle, active, deactivating
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SCI_IDLE   = 2'b00,
    SCI_ACTIVE = 2'b01,
    SCI_DEACT  = 2'b11
  } sci_state_e;
endpackage
`default_nettype wire

// [sci_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface sci_if;
  import sci_pkg::*;
  logic              activation_command_n;
  logic              host_reset_in;
  logic              ext_clock_in;
  logic              divider_select_lo;
  logic              divider_select_hi;
  logic              card_voltage_select;
  logic              irq_n_o;
  logic              irq_n_oe;
  logic [NLINES-1:0] host_line_o;
  logic [NLINES-1:0] host_line_oe;
  logic [NLINES-1:0] dev_line_o;
  logic [NLINES-1:0] dev_line_oe;
  wire  [NLINES-1:0] host_line;
  wire               irq_n;

  // ---------------------------------------------------------------
  // Open-drain wires, pulled high when nobody pulls low
  // ---------------------------------------------------------------
  assign host_line = ~((host_line_oe & ~host_line_o) | (dev_line_oe & ~dev_line_o));
  assign irq_n     = ~(irq_n_oe & ~irq_n_o);

  modport dev (
    input  activation_command_n, host_reset_in, ext_clock_in,
    input  divider_select_lo, divider_select_hi, card_voltage_select,
    input  host_line,
    output irq_n_o, irq_n_oe, dev_line_o, dev_line_oe
  );
  modport host (
    output activation_command_n, host_reset_in, ext_clock_in,
    output divider_select_lo, divider_select_hi, card_voltage_select,
    output host_line_o, host_line_oe,
    input  host_line, irq_n
  );
endinterface
`default_nettype wire

// [sci_host.sv]
`timescale 1ns/1ps
`default_nettype none
module sci_host
  import sci_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  sci_if.host              dif
);
  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == CTRL_OFF) || (a == STAT_OFF) || (a == XDIV_OFF);
  endfunction

  logic [CTRL_W-1:0] ctrl_r;
  logic [7:0]        xdiv_r;
  logic [31:0]       rdata_r;
  logic [3:0]        st1_r;
  logic [3:0]        st2_r;
  logic              access;

  assign access    = psel_i & penable_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = access & ~reg_hit(paddr_i);
  assign prdata_o  = rdata_r;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_r <= CTRL_RST;
      xdiv_r <= XDIV_RST;
    end else if (ce_i && access && pwrite_i) begin
      if (paddr_i == CTRL_OFF) begin
        ctrl_r <= pwdata_i[CTRL_W-1:0];
      end
      if (paddr_i == XDIV_OFF) begin
        xdiv_r <= pwdata_i[7:0];
      end
    end
  end

  // Read data is caught in the setup cycle, so it stands for the access
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= '0;
    end else if (ce_i && psel_i && !penable_i) begin
      rdata_r <= '0;
      if (paddr_i == CTRL_OFF) begin
        rdata_r <= {21'h0, ctrl_r};
      end else if (paddr_i == STAT_OFF) begin
        rdata_r <= {28'h0, st2_r};
      end else if (paddr_i == XDIV_OFF) begin
        rdata_r <= {24'h0, xdiv_r};
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin status synchroniser: interrupt pending, then line levels
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st1_r <= 4'he;
      st2_r <= 4'he;
    end else if (ce_i) begin
      st1_r <= {dif.host_line, ~dif.irq_n};
      st2_r <= st1_r;
    end
  end

  // ---------------------------------------------------------------
  // External clock for the device, half period of xdiv_r cycles
  // ---------------------------------------------------------------
  logic [7:0] xcnt_r;
  logic       xclk_r;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      xcnt_r <= '0;
      xclk_r <= 1'b0;
    end else if (ce_i) begin
      if (xcnt_r + 8'h1 >= xdiv_r) begin
        xcnt_r <= '0;
        xclk_r <= ~xclk_r;
      end else begin
        xcnt_r <= xcnt_r + 8'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  // Command is active low; a new activation needs a 0 then 1 in ACT
  assign dif.activation_command_n = ~ctrl_r[CTRL_ACT];
  assign dif.host_reset_in        = ctrl_r[CTRL_RESET];
  assign dif.card_voltage_select  = ctrl_r[CTRL_VSEL];
  assign dif.divider_select_lo    = ctrl_r[CTRL_DIV_LO];
  assign dif.divider_select_hi    = ctrl_r[CTRL_DIV_HI];
  assign dif.ext_clock_in         = xclk_r;
  assign dif.host_line_o          = '0;
  assign dif.host_line_oe         = ctrl_r[CTRL_PULL +: NLINES];
endmodule
`default_nettype wire

// [sci_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module sci_monitor
  import sci_pkg::*;
#(
  parameter int unsigned DEBOUNCE = DEBOUNCE_CYC
) (
  input wire logic              clock_i,
  input wire logic              resetn_i,
  input wire logic              activation_command_n,
  input wire logic              host_reset_in,
  input wire logic              card_voltage_select,
  input wire logic              irq_n,
  input wire logic [NLINES-1:0] host_line,
  input wire logic [NLINES-1:0] dev_line_oe,
  input wire logic              host_supply_low_i,
  input wire logic              supply_overload_i,
  input wire logic              card_presence_in_n_i,
  input wire logic              card_presence_in_i,
  input wire logic [NLINES-1:0] card_line_i,
  input wire logic [NLINES-1:0] card_line_oe,
  input wire logic              card_supply_out_o,
  input wire logic              card_supply_high_o,
  input wire logic              card_reset_out_o,
  input wire logic              card_active_o
);
  // ---------------------------------------------------------------
  // Removal is taken at once, so sync and state delay suffice
  // ---------------------------------------------------------------
  localparam int RM_MAX = 6;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  a_act_needs_card: assert property (
    $rose(card_active_o) |-> !activation_command_n && $past(card_presence_in_i || !card_presence_in_n_i, 3))
    else $error("activation without card or command");
  a_supply_after_cmd: assert property (
    $rose(card_supply_out_o) |-> $past(!activation_command_n, 3))
    else $error("card supply rose without command");
  a_reset_relay: assert property (
    (card_active_o && $stable(host_reset_in)) [*5] |-> card_reset_out_o == host_reset_in)
    else $error("card reset differs from host reset");
  a_lockout_off: assert property (
    host_supply_low_i [*6] |-> card_line_oe == '0 && !card_supply_out_o)
    else $error("card pins driven during lockout");
  a_irq_cause: assert property (
    $fell(irq_n) |-> $past(supply_overload_i || card_presence_in_i || !card_presence_in_n_i, 3))
    else $error("interrupt without cause");
  a_irq_overload: assert property (
    supply_overload_i |-> ##[1:4] !irq_n)
    else $error("overload gave no interrupt");
  a_io_to_host: assert property (
    $fell(card_line_i[LINE_IO]) && !card_line_oe[LINE_IO] && card_active_o |-> ##[2:4] dev_line_oe[LINE_IO])
    else $error("card low on serial line not relayed");
  a_c4_to_card: assert property (
    $fell(host_line[LINE_C4]) && !dev_line_oe[LINE_C4] && card_active_o |-> ##[2:4] card_line_oe[LINE_C4])
    else $error("host low on first aux line not relayed");
  a_c8_release: assert property (
    $rose(host_line[LINE_C8]) && card_line_oe[LINE_C8] |-> ##[1:4] !card_line_oe[LINE_C8])
    else $error("second aux line not released");
  a_vsel_follow: assert property (
    (card_active_o && $stable(card_voltage_select)) [*5] |-> card_supply_high_o == card_voltage_select)
    else $error("card supply level differs from select");
  a_removal_deact: assert property (
    $fell(card_presence_in_i || !card_presence_in_n_i) && card_active_o |-> ##[2:RM_MAX] !card_active_o)
    else $error("no deactivation after removal");
  a_overload_deact: assert property (
    supply_overload_i && card_active_o |-> ##[1:4] !card_active_o)
    else $error("no deactivation after overload");

  c_activation: cover property ($rose(card_supply_out_o));
  c_interrupt: cover property ($fell(irq_n));
  c_relay: cover property (|card_line_oe);
endmodule
`default_nettype wire

// [test_smart_card_host_pin_interface.sv]
`timescale 1ns/1ps
`default_nettype none
module test_smart_card_host_pin_interface
  import sci_pkg::*;
;
  localparam int unsigned DEB = 8;
  logic              clock_i, resetn_i, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, q;
  logic              host_low, ovl, pres_n, pres, sup, sup_hi, crst, cclk, cact;
  logic [NLINES-1:0] card_drv, card_line, card_line_o, card_line_oe;
  int                errors, n_checks;

  // Card contacts carry a pull-up, so a released line reads high
  assign card_line = ~((card_line_oe & ~card_line_o) | card_drv);

  sci_if sci_if_i ();
  sci_dev #(.DEBOUNCE(DEB)) sci_dev_i (.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(1'b1), .hif(sci_if_i),
    .host_supply_low_i(host_low), .supply_overload_i(ovl), .card_presence_in_n_i(pres_n),
    .card_presence_in_i(pres), .card_line_i(card_line), .card_supply_out_o(sup), .card_supply_high_o(sup_hi),
    .card_reset_out_o(crst), .card_clock_out_o(cclk), .card_line_o(card_line_o), .card_line_oe(card_line_oe),
    .card_active_o(cact));
  sci_host sci_host_i (.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(1'b1), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .dif(sci_if_i));
  sci_monitor #(.DEBOUNCE(DEB)) sci_monitor_i (.clock_i(clock_i), .resetn_i(resetn_i),
    .activation_command_n(sci_if_i.activation_command_n), .host_reset_in(sci_if_i.host_reset_in),
    .card_voltage_select(sci_if_i.card_voltage_select), .irq_n(sci_if_i.irq_n), .host_line(sci_if_i.host_line),
    .dev_line_oe(sci_if_i.dev_line_oe), .host_supply_low_i(host_low), .supply_overload_i(ovl),
    .card_presence_in_n_i(pres_n), .card_presence_in_i(pres), .card_line_i(card_line),
    .card_line_oe(card_line_oe), .card_supply_out_o(sup), .card_supply_high_o(sup_hi),
    .card_reset_out_o(crst), .card_active_o(cact));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check(sci_if_i.activation_command_n, 1'b1);
    check(sci_if_i.irq_n, 1'b1);
    bus(1'b0, CTRL_OFF, 32'h0);
    check(q, 32'h0);
    bus(1'b0, STAT_OFF, 32'h0);
    check(q, 32'he);
    bus(1'b0, XDIV_OFF, 32'h0);
    check(q, 32'h1);
    bus(1'b0, 12'h00c, 32'h0);
    check({q[31:1], e}, 32'h1);
  endtask

  task automatic t_no_card();
    bus(1'b1, CTRL_OFF, 32'h1);
    cyc(10);
    check(sup, 1'b0);
    bus(1'b1, CTRL_OFF, 32'h0);
    ovl <= 1'b1;
    cyc(5);
    check(sci_if_i.irq_n, 1'b0);
    ovl <= 1'b0;
    cyc(6);
    check(sci_if_i.irq_n, 1'b1);
  endtask

  task automatic t_insert();
    pres_n <= 1'b0;
    cyc(5);
    check(sci_if_i.irq_n, 1'b1);
    cyc(12);
    check(sci_if_i.irq_n, 1'b0);
    pres_n <= 1'b1;
    cyc(DEB + 6);
    check(sci_if_i.irq_n, 1'b1);
    pres <= 1'b1;
    cyc(DEB + 8);
    bus(1'b0, STAT_OFF, 32'h0);
    check({31'h0, q[0]}, 32'h1);
  endtask

  task automatic t_ratios();
    logic [31:0] cnt;
    logic        prev;
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, CTRL_OFF, 32'h1 | (r[1] << 1) | (r[0] << 2) | (r << 3));
      cyc(24);
      check(sup, 1'b1);
      check(sup_hi, r[0]);
      check(crst, r[1]);
      cnt = 32'h0;
      prev = cclk;
      repeat (64) begin
        @(posedge clock_i);
        if (cclk && !prev) begin
          cnt++;
        end
        prev = cclk;
      end
      check(cnt, 32'h20 >> r);
      bus(1'b1, CTRL_OFF, 32'h0);
      cyc(10);
      check(sup, 1'b0);
    end
  endtask

  task automatic t_relay();
    bus(1'b1, CTRL_OFF, 32'h1);
    cyc(8);
    for (int i = 0; i < NLINES; i++) begin
      bus(1'b1, CTRL_OFF, 32'h1 | (32'h100 << i));
      cyc(6);
      check({card_line_oe[i], card_line[i]}, 32'h2);
      bus(1'b1, CTRL_OFF, 32'h1);
      cyc(12);
      check(card_line_oe[i], 1'b0);
      card_drv[i] <= 1'b1;
      cyc(6);
      bus(1'b0, STAT_OFF, 32'h0);
      check({29'h0, q[3:1]}, {29'h0, 3'h7 ^ (3'h1 << i)});
      card_drv[i] <= 1'b0;
      cyc(12);
      check(sci_if_i.host_line[i], 1'b1);
    end
    bus(1'b1, CTRL_OFF, 32'h0);
    cyc(10);
  endtask

  task automatic t_faults();
    bus(1'b1, CTRL_OFF, 32'h101);
    cyc(8);
    host_low <= 1'b1;
    cyc(8);
    check({card_line_oe, sup}, 32'h0);
    host_low <= 1'b0;
    bus(1'b1, CTRL_OFF, 32'h0);
    cyc(10);
    bus(1'b1, CTRL_OFF, 32'h1);
    cyc(8);
    check(sup, 1'b1);
    ovl <= 1'b1;
    cyc(6);
    check(cact, 1'b0);
    ovl <= 1'b0;
    bus(1'b1, CTRL_OFF, 32'h0);
    cyc(10);
    bus(1'b1, CTRL_OFF, 32'h1);
    cyc(8);
    pres <= 1'b0;
    cyc(DEB + 8);
    check({cact, sci_if_i.irq_n}, 32'h1);
    bus(1'b1, CTRL_OFF, 32'h0);
  endtask

  // ---------------------------------------------------------------
  // Clock, main sequence, watchdog
  // ---------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  initial begin
    resetn_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    host_low = 1'b0;
    ovl = 1'b0;
    pres_n = 1'b1;
    pres = 1'b0;
    card_drv = '0;
    errors = 0;
    n_checks = 0;
    repeat (10) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_reset();
    t_no_card();
    t_insert();
    t_ratios();
    t_relay();
    t_faults();
    final_report();
  end

  // Whole run is under eight hundred cycles; twenty-five times that means a hang
  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
